// ==== logic/asp_pkg.sv ====
package asp_pkg;

  // ****************************************************************
  // Register map and field layout.
  // ****************************************************************
  localparam logic [7:0] ADDR_CONTROL = 8'h80;
  localparam logic [7:0] ADDR_STATUS = 8'h82;
  localparam logic [7:0] ADDR_TX_HOLDING = 8'h84;
  localparam logic [7:0] ADDR_RX_BUFFER = 8'h86;
  localparam logic [7:0] ADDR_RATE_DIVISOR = 8'h88;

  localparam int CTL_RX_EN = 0;
  localparam int CTL_RX_EXC_IE = 1;
  localparam int CTL_TX_EN = 2;
  localparam int CTL_TWO_STOP = 3;
  localparam int CTL_EIGHT_BIT = 4;
  localparam int CTL_PAR_LO = 5;
  localparam int CTL_PAR_HI = 6;
  localparam int CTL_HOLD_LEVEL = 7;
  localparam int CTL_LINE_HOLD = 8;
  localparam int CTL_ECHO = 9;
  localparam int CTL_RX_IE = 10;
  localparam int CTL_TX_IE = 11;
  localparam logic [15:0] CTL_WRITE_MASK = 16'h0fff;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;

  localparam int STS_OVERRUN = 0;
  localparam int STS_PARITY = 1;
  localparam int STS_FRAMING = 2;
  localparam int STS_BREAK = 3;
  localparam int STS_RX_READY = 4;
  localparam int STS_TX_HOLD_EMPTY = 5;
  localparam int STS_TX_IDLE = 6;

  localparam logic [15:0] DIVISOR_RESET = 16'h0000;
  localparam logic [7:0] IRQ_TYPE = 8'h14;
  localparam logic [3:0] OVERSAMPLE = 4'hf;
  localparam logic [3:0] MID_SAMPLE = 4'h7;
  localparam logic [3:0] BREAK_BITS = 4'hc;
  localparam int FIFO_DEPTH = 32;

  // ****************************************************************
  // Carriers.
  // ****************************************************************
  typedef struct packed {
    logic sel;
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } asp_bus_s;

  typedef struct packed {
    logic [1:0] parity;
    logic eight;
    logic two_stop;
  } asp_fmt_s;

endpackage : asp_pkg

// ==== logic/asp_fifo.sv ====
`timescale 1ns/1ps
// ******************************************************************
// Valid/ready FIFO with honest full and empty.
// ******************************************************************
module asp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic arst_n,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Full when pointers differ only in the wrap bit.
  assign in_ready = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
  assign out_valid = wp_r != rp_r;
  assign out_data = mem[rp_r[AW-1:0]];

  // Storage has no reset; only the pointers define content.
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end

  // Pointer update.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_r + (AW+1)'(push);
      rp_r <= rp_r + (AW+1)'(pop);
    end
  end
endmodule : asp_fifo

// ==== logic/asp_port.sv ====
`timescale 1ns/1ps
// Behaviour
// - Seven or eight data bits per character.
// - Parity field: none, odd, or even.
// - Parity bit added after data bits.
// - One or two stop bits.
// - Transmit enable gates transmitter and its interrupt.
// - Receive enable gates receiver and its interrupts.
// - Interrupt while holding empty and enabled.
// - Interrupt while receive data ready and enabled.
// - Exception interrupt on break or errors.
// - Echo mode: pin high, transmit feeds receive.
// - Line hold drives constant pin level.
// - Hold level selects high or low.
// - Break is low longer than one frame.
// - Reset clears control register.
// - One combined interrupt with fixed type.
// - Transmit double buffered; receive has a 32-entry FIFO ahead of the buffer register.
// - No DMA request path exists.
// - One output pin, one input pin, full duplex.
// - Holding empty flag clears on data write.
// - Ready flag clears on data read unless the FIFO holds another character.
// - Idle flag: nothing waiting, shifter empty.
// - Divisor counts half periods of 16x clock.
module asp_port
  import asp_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic arst_n,
  // Peripheral register access.
  input wire asp_pkg::asp_bus_s bus,
  output logic [15:0] rdata,
  // Serial line.
  output logic serial_out_pin,
  input wire logic serial_in_pin,
  // Interrupt request and its type.
  output logic irq,
  output logic [7:0] irq_type
);
  import asp_pkg::*;

  // ****************************************************************
  // Registers and bus decode.
  // ****************************************************************
  logic [15:0] control_r;
  logic [15:0] divisor_r;
  logic [7:0] hold_r;
  logic hold_full_r;
  logic [3:0] err_r;
  wire wr_ctl = bus.sel && bus.wr && bus.addr == ADDR_CONTROL;
  wire wr_sts = bus.sel && bus.wr && bus.addr == ADDR_STATUS;
  wire wr_tx = bus.sel && bus.wr && bus.addr == ADDR_TX_HOLDING;
  wire wr_div = bus.sel && bus.wr && bus.addr == ADDR_RATE_DIVISOR;
  wire rd_rx = bus.sel && bus.rd && bus.addr == ADDR_RX_BUFFER;
  wire tx_en = control_r[CTL_TX_EN];
  wire rx_en = control_r[CTL_RX_EN];
  wire echo = control_r[CTL_ECHO];
  asp_fmt_s fmt;
  assign fmt = '{parity: control_r[CTL_PAR_HI:CTL_PAR_LO], eight: control_r[CTL_EIGHT_BIT],
                 two_stop: control_r[CTL_TWO_STOP]};

  // Control, divisor and holding registers; reserved bits stay zero.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      control_r <= CONTROL_RESET;
      divisor_r <= DIVISOR_RESET;
      hold_r <= 8'h00;
    end else begin
      if (wr_ctl) control_r <= bus.wdata & CTL_WRITE_MASK;
      if (wr_div) divisor_r <= bus.wdata;
      if (wr_tx) hold_r <= bus.wdata[7:0];
    end
  end

  // ****************************************************************
  // Sixteen-times tick: divisor+1 clocks per phase, two phases each.
  // ****************************************************************
  logic [15:0] div_cnt_r;
  logic phase_r;
  // A divisor lowered below the running count must not stall the tick for a whole wrap.
  wire div_end = div_cnt_r >= divisor_r;
  wire tick = div_end && phase_r;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_r <= 16'h0000;
      phase_r <= 1'b0;
    end else begin
      div_cnt_r <= div_end ? 16'h0000 : div_cnt_r + 16'h0001;
      if (div_end) phase_r <= ~phase_r;
    end
  end

  // ****************************************************************
  // Transmitter: holding register feeds a frame shifter.
  // ****************************************************************
  logic tx_busy_r;
  logic [11:0] tx_shift_r;
  logic [3:0] tx_bits_r;
  logic [3:0] tx_sub_r;
  logic tx_line_r;
  wire [7:0] tx_data = fmt.eight ? hold_r : {1'b0, hold_r[6:0]};
  wire tx_par_bit = ^tx_data ^ ~fmt.parity[0];
  // Cells per frame: start, seven or eight data, optional parity, one or two stops.
  wire [3:0] tx_len = 4'd9 + 4'(fmt.eight) + 4'(fmt.parity[1]) + 4'(fmt.two_stop);
  wire tx_load = tx_en && !tx_busy_r && hold_full_r && tick;
  wire [11:0] tx_frame_7 = fmt.parity[1] ? {3'b111, tx_par_bit, tx_data[6:0], 1'b0} : {4'b1111, tx_data[6:0], 1'b0};
  wire [11:0] tx_frame_8 = fmt.parity[1] ? {2'b11, tx_par_bit, tx_data, 1'b0} : {3'b111, tx_data, 1'b0};
  wire tx_next_line = tx_busy_r ? tx_shift_r[0] : 1'b1;
  wire pin_level = echo ? 1'b1 : control_r[CTL_LINE_HOLD] ? control_r[CTL_HOLD_LEVEL] : tx_line_r;
  wire tx_step = tx_busy_r && tick && tx_sub_r == OVERSAMPLE;

  // Frame shifter; a disabled transmitter holds the line idle.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_busy_r <= 1'b0;
      tx_shift_r <= 12'hfff;
      tx_bits_r <= 4'h0;
      tx_sub_r <= 4'h0;
      tx_line_r <= 1'b1;
    end else begin
      tx_line_r <= tx_next_line;
      if (!tx_en) begin
        tx_busy_r <= 1'b0;
      end else if (tx_load) begin
        tx_busy_r <= 1'b1;
        tx_shift_r <= fmt.eight ? tx_frame_8 : tx_frame_7;
        tx_bits_r <= tx_len;
        tx_sub_r <= 4'h0;
      end else if (tx_busy_r && tick) begin
        tx_sub_r <= tx_sub_r + 4'h1;
        if (tx_step) begin
          tx_shift_r <= {1'b1, tx_shift_r[11:1]};
          tx_bits_r <= tx_bits_r - 4'h1;
          if (tx_bits_r == 4'h1) tx_busy_r <= 1'b0;
        end
      end
    end
  end

  // Holding register full flag: write sets it, the load empties it.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) hold_full_r <= 1'b0;
    else if (wr_tx) hold_full_r <= 1'b1;
    else if (tx_load) hold_full_r <= 1'b0;
  end

  // ****************************************************************
  // Receiver front end: synchroniser and echo path.
  // ****************************************************************
  logic rx_s1_r;
  logic rx_s2_r;
  logic rx_prev_r;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
    end else begin
      rx_s1_r <= serial_in_pin;
      rx_s2_r <= rx_s1_r;
    end
  end
  wire rx_line = echo ? tx_line_r : rx_s2_r;

  // ****************************************************************
  // Receiver: start edge, mid-cell sampling, checks.
  // ****************************************************************
  logic rx_busy_r;
  logic [3:0] rx_sub_r;
  logic [3:0] rx_idx_r;
  logic [9:0] rx_shift_r;
  logic [3:0] low_bits_r;
  logic [3:0] low_sub_r;
  logic break_seen_r;
  wire [3:0] rx_data_bits = 4'd7 + 4'(fmt.eight);
  wire [3:0] rx_last = rx_data_bits + 4'(fmt.parity[1]) + 4'h1; // first stop bit index
  wire rx_sample = rx_busy_r && tick && rx_sub_r == MID_SAMPLE;
  wire rx_start = rx_en && !rx_busy_r && rx_prev_r && !rx_line;
  wire rx_done = rx_sample && rx_idx_r == rx_last;
  wire [7:0] rx_data = fmt.eight ? rx_shift_r[7:0] : {1'b0, rx_shift_r[6:0]};
  wire rx_par_rx = fmt.eight ? rx_shift_r[8] : rx_shift_r[7];
  wire rx_par_bad = fmt.parity[1] && (rx_par_rx != (^rx_data ^ ~fmt.parity[0]));
  wire rx_frame_bad = !rx_line;
  wire [3:0] frame_bits = tx_len;
  wire break_hit = low_bits_r > frame_bits;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_prev_r <= 1'b1;
      rx_busy_r <= 1'b0;
      rx_sub_r <= 4'h0;
      rx_idx_r <= 4'h0;
      rx_shift_r <= 10'h000;
    end else begin
      rx_prev_r <= rx_line;
      if (!rx_en) begin
        rx_busy_r <= 1'b0;
      end else if (rx_start) begin
        rx_busy_r <= 1'b1;
        rx_sub_r <= 4'h0;
        rx_idx_r <= 4'h0;
      end else if (rx_busy_r && tick) begin
        rx_sub_r <= rx_sub_r + 4'h1;
        if (rx_sample) begin
          rx_idx_r <= rx_idx_r + 4'h1;
          if (rx_idx_r == 4'h0 && rx_line) rx_busy_r <= 1'b0;
          else if (rx_idx_r != 4'h0 && !rx_done) rx_shift_r[rx_idx_r - 4'h1] <= rx_line;
          if (rx_done) rx_busy_r <= 1'b0;
        end
      end
    end
  end

  // Low-line timer in bit cells; one break event per low stretch.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_bits_r <= 4'h0;
      low_sub_r <= 4'h0;
      break_seen_r <= 1'b0;
    end else if (rx_line || !rx_en) begin
      low_bits_r <= 4'h0;
      low_sub_r <= 4'h0;
      break_seen_r <= 1'b0;
    end else if (tick) begin
      low_sub_r <= low_sub_r + 4'h1;
      if (low_sub_r == OVERSAMPLE && !break_hit) low_bits_r <= low_bits_r + 4'h1;
      if (break_hit) break_seen_r <= 1'b1;
    end
  end

  // ****************************************************************
  // Receive FIFO ahead of the buffer register; a character arriving while it is full is dropped.
  // ****************************************************************
  logic fifo_out_valid;
  logic fifo_in_ready;
  logic [9:0] fifo_out;
  logic [7:0] rx_buf_r;
  logic rx_ready_r;
  wire rx_push = rx_done && fifo_in_ready;
  wire rx_load = fifo_out_valid && (!rx_ready_r || rd_rx);

  asp_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .in_valid(rx_done),
    .in_ready(fifo_in_ready),
    .in_data({rx_par_bad, rx_frame_bad, rx_data}),
    .out_valid(fifo_out_valid),
    .out_ready(rx_load),
    .out_data(fifo_out)
  );

  // Buffer register; a read frees it for the next character.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_buf_r <= 8'h00;
      rx_ready_r <= 1'b0;
    end else begin
      if (rx_load) rx_buf_r <= fifo_out[7:0];
      if (rx_load) rx_ready_r <= 1'b1;
      else if (rd_rx) rx_ready_r <= 1'b0;
    end
  end

  // Sticky error flags; a new event wins over a software clear.
  wire [3:0] err_set = {break_hit && !break_seen_r, rx_load && fifo_out[8],
                        rx_load && fifo_out[9], rx_done && !fifo_in_ready};
  wire [3:0] err_clr = wr_sts ? ~bus.wdata[3:0] : 4'h0;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) err_r <= 4'h0;
    else err_r <= (err_r & ~err_clr) | err_set;
  end

  // ****************************************************************
  // Status, read mux and interrupt.
  // ****************************************************************
  wire tx_idle = !hold_full_r && !tx_busy_r;
  wire [15:0] status = {9'h000, tx_idle, !hold_full_r, rx_ready_r, err_r};
  // Data moves only through these reads; there is no request line for a transfer engine.
  wire [15:0] rd_mux = bus.addr == ADDR_CONTROL ? control_r :
                       bus.addr == ADDR_STATUS ? status :
                       bus.addr == ADDR_TX_HOLDING ? {8'h00, hold_r} :
                       bus.addr == ADDR_RX_BUFFER ? {8'h00, rx_buf_r} :
                       bus.addr == ADDR_RATE_DIVISOR ? divisor_r : 16'h0000;
  wire irq_nxt = (tx_en && control_r[CTL_TX_IE] && !hold_full_r) ||
                 (rx_en && control_r[CTL_RX_IE] && rx_ready_r) ||
                 (rx_en && control_r[CTL_RX_EXC_IE] && (err_r != 4'h0));

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 16'h0000;
      irq <= 1'b0;
      irq_type <= 8'h00;
      serial_out_pin <= 1'b1;
    end else begin
      rdata <= (bus.sel && bus.rd) ? rd_mux : 16'h0000;
      irq <= irq_nxt;
      irq_type <= IRQ_TYPE;
      serial_out_pin <= pin_level;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  a_reset_ctl: assert property (@(posedge sys_clk) $rose(arst_n) |-> control_r == 16'h0000)
    else $error("control not cleared by reset");
  a_hold_clear: assert property (@(posedge sys_clk) disable iff (!arst_n) wr_tx |=> !status[STS_TX_HOLD_EMPTY])
    else $error("holding empty not cleared by write");
  a_ready_clear: assert property (@(posedge sys_clk) disable iff (!arst_n)
    rd_rx && !rx_load |=> !rx_ready_r)
    else $error("ready flag not cleared by read");
  a_echo_pin: assert property (@(posedge sys_clk) disable iff (!arst_n) echo |=> serial_out_pin)
    else $error("echo mode pin not high");
  a_hold_level: assert property (@(posedge sys_clk) disable iff (!arst_n)
    control_r[CTL_LINE_HOLD] && !echo |=> serial_out_pin == $past(control_r[CTL_HOLD_LEVEL]))
    else $error("held line level wrong");
  a_tx_off: assert property (@(posedge sys_clk) disable iff (!arst_n) !tx_en |=> !tx_busy_r)
    else $error("transmitter active while disabled");
  a_rx_irq: assert property (@(posedge sys_clk) disable iff (!arst_n)
    rx_en && control_r[CTL_RX_IE] && rx_ready_r |=> irq)
    else $error("receive irq missing");
  a_tx_irq: assert property (@(posedge sys_clk) disable iff (!arst_n)
    tx_en && control_r[CTL_TX_IE] && !hold_full_r |=> irq)
    else $error("transmit irq missing");
  // An idle transmitter with nothing written must not start shifting on its own.
  a_idle_flag: assert property (@(posedge sys_clk) disable iff (!arst_n)
    status[STS_TX_IDLE] && !wr_tx |=> !tx_busy_r && status[STS_TX_IDLE])
    else $error("idle flag with work pending");
  a_overrun_set: assert property (@(posedge sys_clk) disable iff (!arst_n)
    rx_done && !fifo_in_ready |=> err_r[STS_OVERRUN])
    else $error("overrun not flagged");

  // Receive-side checks; every flag is looked at one cycle after its event.
  a_rx_off: assert property (@(posedge sys_clk) disable iff (!arst_n) !rx_en |=> !rx_busy_r)
    else $error("receiver active while disabled");
  a_frame_flag: assert property (@(posedge sys_clk) disable iff (!arst_n)
    rx_load && fifo_out[8] |=> err_r[STS_FRAMING])
    else $error("framing error not flagged");
  a_parity_flag: assert property (@(posedge sys_clk) disable iff (!arst_n)
    rx_load && fifo_out[9] |=> err_r[STS_PARITY])
    else $error("parity error not flagged");
  a_break_flag: assert property (@(posedge sys_clk) disable iff (!arst_n)
    break_hit && !break_seen_r |=> err_r[STS_BREAK])
    else $error("break not flagged");
  a_exc_irq: assert property (@(posedge sys_clk) disable iff (!arst_n)
    rx_en && control_r[CTL_RX_EXC_IE] && err_r != 4'h0 |=> irq)
    else $error("exception irq missing");
  // The type code is loaded on the first edge after reset and never changes.
  a_irq_type: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $past(arst_n) |-> irq_type == IRQ_TYPE)
    else $error("interrupt type wrong");

  // Main scenarios that the bench is expected to reach.
  c_tx_frame: cover property (@(posedge sys_clk) disable iff (!arst_n) tx_load);
  c_rx_frame: cover property (@(posedge sys_clk) disable iff (!arst_n) rx_done);
  c_break: cover property (@(posedge sys_clk) disable iff (!arst_n) err_set[STS_BREAK]);
  c_echo: cover property (@(posedge sys_clk) disable iff (!arst_n) echo && rx_done);
  c_overrun: cover property (@(posedge sys_clk) disable iff (!arst_n) err_set[STS_OVERRUN]);
endmodule : asp_port

// ==== tb/asp_remote.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Far-end serial device: sends frames on request, decodes frames.
// ****************************************************************
module asp_remote
  import asp_pkg::*;
#(
  parameter int BIT_CLKS = 32
) (
  // Clock.
  input wire logic sys_clk,
  // Line format in use.
  input wire asp_pkg::asp_fmt_s fmt,
  // Serial lines.
  input wire logic line_in,
  output logic line_out
);
  int rx_cnt = 0;
  logic [7:0] rx_data;
  logic frame_ok;
  logic [7:0] rd_d;
  logic rd_ok;
  time gap;
  time t0;
  time last_t = 0;

  // The line rests at the high mark level, as a pulled-up line does.
  initial line_out = 1'b1;

  // Waits whole bit cells; changes land just after the edge, never on it.
  task automatic wait_bits(input int n);
    repeat (n * BIT_CLKS) @(posedge sys_clk);
    #1;
  endtask : wait_bits

  // Sends one frame; can flip the parity bit or pull the stop bits low.
  task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
    logic p;
    p = ^(fmt.eight ? d : {1'b0, d[6:0]}) ^ ~fmt.parity[0] ^ bad_par;
    line_out = 1'b0;
    wait_bits(1);
    for (int i = 0; i < (fmt.eight ? 8 : 7); i++) begin
      line_out = d[i];
      wait_bits(1);
    end
    if (fmt.parity[1]) begin
      line_out = p;
      wait_bits(1);
    end
    line_out = ~bad_stop;
    wait_bits(fmt.two_stop ? 2 : 1);
    line_out = 1'b1;
    wait_bits(1);
  endtask : send

  // Holds the line low for a number of bit cells, then returns to mark.
  task automatic hold_low(input int n);
    line_out = 1'b0;
    wait_bits(n);
    line_out = 1'b1;
    wait_bits(2);
  endtask : hold_low

  // Decodes each frame at mid-cell; parity and every stop bit must hold.
  always begin
    @(negedge line_in);
    t0 = $time;
    repeat (BIT_CLKS / 2) @(posedge sys_clk);
    if (line_in === 1'b0) begin
      rd_ok = 1'b1;
      rd_d = 8'h00;
      for (int i = 0; i < (fmt.eight ? 8 : 7); i++) begin
        repeat (BIT_CLKS) @(posedge sys_clk);
        rd_d[i] = line_in;
      end
      if (fmt.parity[1]) begin
        repeat (BIT_CLKS) @(posedge sys_clk);
        rd_ok = rd_ok & ((^rd_d ^ line_in) === ~fmt.parity[0]);
      end
      for (int s = 0; s < (fmt.two_stop ? 2 : 1); s++) begin
        repeat (BIT_CLKS) @(posedge sys_clk);
        rd_ok = rd_ok & (line_in === 1'b1);
      end
      rx_data = rd_d;
      frame_ok = rd_ok;
      gap = t0 - last_t;
      last_t = t0;
      rx_cnt++;
    end
  end
endmodule : asp_remote

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench for the serial port.
// ****************************************************************
module tb_top;
  import asp_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n;
  asp_bus_s bus;
  asp_fmt_s fmt;
  logic [15:0] rdata;
  logic serial_out_pin;
  logic serial_in_pin;
  logic irq;
  logic [7:0] irq_type;
  logic [15:0] q;
  logic [15:0] c;
  logic [7:0] d;
  logic [7:0] d0;
  logic [7:0] mask;
  int fails = 0;
  int tests_run = 0;
  int hi_n = 0;
  int lo_n = 0;

  asp_port DUT (.sys_clk(sys_clk), .arst_n(arst_n), .bus(bus), .rdata(rdata), .serial_out_pin(serial_out_pin),
    .serial_in_pin(serial_in_pin), .irq(irq), .irq_type(irq_type));
  asp_remote #(.BIT_CLKS(32)) u_remote (.sys_clk(sys_clk), .fmt(fmt), .line_in(serial_out_pin),
    .line_out(serial_in_pin));

  // 25 MHz clock; divisor 0 makes a bit cell 32 clocks.
  always #20 sys_clk = ~sys_clk;

  // Counts line levels so held-line scenarios can see any glitch.
  always @(posedge sys_clk) begin
    if (serial_out_pin === 1'b1) hi_n++;
    else lo_n++;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One register access: strobes last one cycle, read data is taken next cycle.
  task automatic acc(input logic [7:0] a, input logic w, input logic [15:0] wd, output logic [15:0] rq);
    @(posedge sys_clk);
    #1 bus = '{sel: 1'b1, rd: ~w, wr: w, addr: a, wdata: wd};
    @(posedge sys_clk);
    #1 bus = '0;
    rq = rdata;
  endtask : acc

  task automatic wr(input logic [7:0] a, input logic [15:0] wd);
    logic [15:0] x;
    acc(a, 1'b1, wd, x);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] rq);
    acc(a, 1'b0, 16'h0000, rq);
  endtask : rd

  task automatic set_ctl(input logic [15:0] v);
    fmt = '{parity: v[6:5], eight: v[4], two_stop: v[3]};
    mask = v[4] ? 8'hff : 8'h7f;
    wr(ADDR_CONTROL, v);
  endtask : set_ctl

  // Polls one status bit under a bounded count.
  task automatic wait_sts(input int b, input logic v);
    for (int i = 0; i < 3000; i++) begin
      rd(ADDR_STATUS, q);
      if (q[b] === v) break;
    end
    chk("status bit", q[b], v);
  endtask : wait_sts

  task automatic wait_cnt(input int n);
    for (int i = 0; i < 20000 && u_remote.rx_cnt < n; i++) @(posedge sys_clk);
    chk("frame count", u_remote.rx_cnt, n);
  endtask : wait_cnt

  // Clears error flags and reads the receive path until it is empty.
  task automatic drain;
    wr(ADDR_STATUS, 16'h0000);
    for (int i = 0; i < 40; i++) begin
      rd(ADDR_STATUS, q);
      if (q[STS_RX_READY] !== 1'b1) break;
      rd(ADDR_RX_BUFFER, q);
    end
  endtask : drain

  function automatic int frame_clks(input logic [15:0] v);
    return (1 + (v[4] ? 8 : 7) + v[6] + (v[3] ? 2 : 1)) * 32 * 40;
  endfunction : frame_clks

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  // Watchdog: the whole sequence needs well under this span.
  initial begin
    #3600000;
    fails++;
    wrap_up();
  end

  // Main sequence.
  initial begin
    bus = '0;
    fmt = '0;
    mask = 8'h7f;
    arst_n = 1'b0;
    void'($urandom(32'hb0c5a174));
    repeat (20) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    rd(ADDR_CONTROL, q);
    chk("control reset", q, CONTROL_RESET);
    chk("irq type", irq_type, IRQ_TYPE);
    wr(ADDR_CONTROL, 16'hf800);
    rd(ADDR_CONTROL, q);
    chk("control mask", q, 16'h0800);
    chk("irq tx off", irq, 1'b0);
    set_ctl(16'h0804);
    wait_sts(STS_TX_HOLD_EMPTY, 1'b1);
    chk("irq tx empty", irq, 1'b1);
    rd(8'h8a, q);
    chk("unmapped", q, 16'h0000);
    c = 16'($urandom);
    wr(ADDR_RATE_DIVISOR, c);
    rd(ADDR_RATE_DIVISOR, q);
    chk("divisor", q, c);
    wr(ADDR_RATE_DIVISOR, 16'h0000);
    $display("test registers done");
    for (int f = 0; f < 8; f++) begin
      c = {9'h000, f[1:0], f[2], f[0] ^ f[1], 3'b100};
      set_ctl(c);
      d0 = 8'($urandom);
      d = 8'($urandom);
      tests_run = tests_run;
      wr(ADDR_TX_HOLDING, {8'h00, d0});
      wait_sts(STS_TX_HOLD_EMPTY, 1'b1);
      wr(ADDR_TX_HOLDING, {8'h00, d});
      rd(ADDR_STATUS, q);
      chk("holding full", q[STS_TX_HOLD_EMPTY], 1'b0);
      wait_cnt(u_remote.rx_cnt + 2);
      chk("tx char", u_remote.rx_data, d & mask);
      chk("tx frame", u_remote.frame_ok, 1'b1);
      // A waiting character starts on the 16x tick after the last stop, two clocks later.
      chk("tx spacing", 32'(u_remote.gap), frame_clks(c) + 80);
      wait_sts(STS_TX_IDLE, 1'b1);
    end
    $display("test transmit done");
    for (int f = 0; f < 8; f++) begin
      c = {9'h008, f[1:0], f[2], f[0] ^ f[1], 3'b001};
      set_ctl(c);
      d = 8'($urandom);
      u_remote.send(d, 1'b0, 1'b0);
      wait_sts(STS_RX_READY, 1'b1);
      chk("irq rx ready", irq, 1'b1);
      rd(ADDR_RX_BUFFER, q);
      chk("rx char", q[7:0], d & mask);
      rd(ADDR_STATUS, q);
      chk("ready cleared", q[STS_RX_READY], 1'b0);
      if (c[6]) begin
        u_remote.send(d, 1'b1, 1'b0);
        wait_sts(STS_PARITY, 1'b1);
        rd(ADDR_RX_BUFFER, q);
        chk("parity char", q[7:0], d & mask);
      end
      u_remote.send(d, 1'b0, 1'b1);
      wait_sts(STS_FRAMING, 1'b1);
      drain();
    end
    $display("test receive done");
    set_ctl(16'h0215);
    d = 8'($urandom);
    lo_n = 0;
    wr(ADDR_TX_HOLDING, {8'h00, d});
    wait_sts(STS_RX_READY, 1'b1);
    chk("echo pin", lo_n, 0);
    rd(ADDR_RX_BUFFER, q);
    chk("echo char", q[7:0], d);
    $display("test echo done");
    for (int lv = 0; lv < 2; lv++) begin
      set_ctl(lv ? 16'h0194 : 16'h0114);
      wait_sts(STS_TX_IDLE, 1'b1);
      hi_n = 0;
      lo_n = 0;
      wr(ADDR_TX_HOLDING, 16'($urandom) & 16'h00ff);
      wait_sts(STS_TX_IDLE, 1'b0);
      wait_sts(STS_TX_IDLE, 1'b1);
      chk("held level", lv ? lo_n : hi_n, 0);
    end
    $display("test line hold done");
    set_ctl(16'h0013);
    drain();
    u_remote.hold_low(12);
    wait_sts(STS_BREAK, 1'b1);
    chk("irq break", irq, 1'b1);
    drain();
    $display("test break done");
    d0 = 8'($urandom);
    u_remote.send(d0, 1'b0, 1'b0);
    repeat (31) u_remote.send(8'($urandom), 1'b0, 1'b0);
    rd(ADDR_STATUS, q);
    chk("no overrun", q[STS_OVERRUN], 1'b0);
    repeat (2) u_remote.send(8'($urandom), 1'b0, 1'b0);
    wait_sts(STS_OVERRUN, 1'b1);
    chk("irq overrun", irq, 1'b1);
    rd(ADDR_RX_BUFFER, q);
    chk("oldest char", q[7:0], d0);
    drain();
    $display("test overrun done");
    wrap_up();
  end
endmodule : tb_top
